// ===== logic/ctf_consts.svh
// Purpose: Offsets, field positions, reset values of the transmit flag block
// Assumes: AXI4-Lite byte addresses, one aligned word per register
// Notes: Definitions only
`ifndef CTF_CONSTS_SVH
`define CTF_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CTF_OFF_FLAGS 8'h00
`define CTF_OFF_TXIE 8'h04
`define CTF_OFF_CTRL 8'h08
`define CTF_OFF_ABORT_REQ 8'h0c
`define CTF_OFF_ABORT_ACK 8'h10
`define CTF_OFF_IST 8'h14
`define CTF_OFF_IMSK 8'h18

// ****************************************
// Fields and reset values
// ****************************************
`define CTF_NBUF 3
`define CTF_CTRL_INIT_REQ_BIT 0
`define CTF_CTRL_LISTEN_BIT 1
`define CTF_CTRL_WAKE_FN_BIT 2
`define CTF_CTRL_WAKE_IRQ_BIT 3
`define CTF_CTRL_INIT_ACK_BIT 4
`define CTF_FLAGS_RST 3'h7
`define CTF_TXIE_RST 3'h0
`define CTF_RESP_OKAY 2'h0
`define CTF_RESP_SLVERR 2'h2

`endif

// ===== logic/ctf_pkg.sv
// Purpose: Types of the transmit flag block
// Assumes: Constants come from ctf_consts.svh
// Notes: Receiver state codes are Gray along ok, warning, error, bus-off
package ctf_pkg;

  typedef enum logic [1:0] {
    CTF_RX_OK = 2'h0,
    CTF_RX_WARN = 2'h1,
    CTF_RX_ERR = 2'h3,
    CTF_RX_BUSOFF = 2'h2
  } ctf_rx_state_t;

  // Signals arriving from the protocol engine
  typedef struct packed {
    logic [2:0] tx_done;
    logic [2:0] tx_failed;
    logic [2:0] tx_active;
    logic tx_bus_off;
    ctf_rx_state_t rx_state;
  } ctf_core_in_t;

  // Signals going to the protocol engine and the buffer RAM
  typedef struct packed {
    logic [2:0] tx_queued;
    logic [2:0] buf_blocked;
    logic listen_mode;
    logic wakeup_function_enable;
    logic wakeup_irq_enable;
    ctf_rx_state_t receiver_error_state;
  } ctf_core_out_t;

endpackage

// ===== logic/ctf_tx_flags.sv
// Purpose: Transmit buffer empty flags, interrupt enables and abort handshake
// Assumes: AXI4-Lite slave, one clock, synchronous active-high reset
// Notes: Only the low byte of each register is implemented
//        Init acknowledge is modelled as a one-cycle echo of the request
//        Software cannot withdraw an abort request; only an empty flag or init mode drops it
//        Error counters and bit timing live in the protocol engine
//
// Behaviour
// - Successful transmission sets the empty flag
// - Granted abort sets the empty flag
// - Interrupt high while enabled flag is set
// - Clearing a flag clears its abort acknowledge
// - Setting a flag clears its abort request
// - Listen mode blocks clears and transmissions
// - Scheduled buffer blocks reads and writes
// - Init mode holds flags, enables and aborts at reset, rejects writes but control and mask
// - Write one clears flag, zero ignored
// - One interrupt enable bit per buffer
// - Transmitter bus-off recovery forces receiver OK
// - Abort granted only before start or after failure
`timescale 1ns/100ps
`include "ctf_consts.svh"

module ctf_tx_flags
  import ctf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ctf_core_in_t core_in,
  output ctf_core_out_t core_out,
  output logic tx_empty_irq,
  output logic irq
);

  // ****************************************
  // Helpers
  // ****************************************
  // Word compare: the two byte-lane bits are ignored, so any byte of a word hits it
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr[7:2] == off[7:2]);
  endfunction

  // Seven word registers; every other word of the window answers with an error
  function automatic logic mapped(input logic [7:0] addr);
    mapped = hit(addr, `CTF_OFF_FLAGS) | hit(addr, `CTF_OFF_TXIE) | hit(addr, `CTF_OFF_CTRL) |
             hit(addr, `CTF_OFF_ABORT_REQ) | hit(addr, `CTF_OFF_ABORT_ACK) | hit(addr, `CTF_OFF_IST) |
             hit(addr, `CTF_OFF_IMSK);
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  // Write path: address and data may arrive in either order
  logic aw_ok_ff;
  logic [7:0] awaddr_ff;
  logic w_ok_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;

  // Read path: one read outstanding at most
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // Per-buffer state, bit n belongs to transmit buffer n
  logic [2:0] flags_ff;
  logic [2:0] txie_ff;
  logic [2:0] abort_req_ff;
  logic [2:0] abort_ack_ff;
  logic [2:0] ist_ff;
  logic [2:0] imsk_ff;

  // Mode and wake-up control
  logic init_rq_ff;
  logic init_ak_ff;
  logic listen_ff;
  logic wake_fn_ff;
  logic wake_irq_ff;

  // Error state tracking
  logic bus_off_ff;
  ctf_rx_state_t rx_state_ff;

  // ****************************************
  // Bus decode
  // ****************************************
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire do_wr = aw_ok_ff & w_ok_ff & ~bvalid_ff;
  wire wr_en = do_wr & wstrb0_ff;
  wire init_active = init_rq_ff & init_ak_ff;
  // Writes only when both init bits are low, so the exit handshake is also protected
  wire wr_open = ~init_rq_ff & ~init_ak_ff;
  wire wr_flags = wr_en & hit(awaddr_ff, `CTF_OFF_FLAGS) & wr_open & ~listen_ff;
  wire wr_txie = wr_en & hit(awaddr_ff, `CTF_OFF_TXIE) & wr_open;
  // Control stays writable in init mode, otherwise init mode could never be left
  wire wr_ctrl = wr_en & hit(awaddr_ff, `CTF_OFF_CTRL);
  wire wr_abort_req = wr_en & hit(awaddr_ff, `CTF_OFF_ABORT_REQ) & wr_open;
  wire wr_imsk = wr_en & hit(awaddr_ff, `CTF_OFF_IMSK);
  // Any accepted read of the status word clears it; software must act on what it read
  wire rd_ist = ar_hs & hit(s_axi_araddr, `CTF_OFF_IST);

  // ****************************************
  // Flag logic
  // ****************************************
  // Abort is only taken while the frame has not started or after it failed
  // Abort is only taken while the frame has not started or after it failed;
  // a frame already on the wire is allowed to finish and counts as sent
  wire [2:0] grant = abort_req_ff & ~flags_ff & (~core_in.tx_active | core_in.tx_failed);

  // A done pulse for a buffer that is already empty is stale and ignored
  wire [2:0] set_flag = (core_in.tx_done & ~flags_ff) | grant;

  // Write one clears, write zero leaves the bit alone
  wire [2:0] clr_req = wr_flags ? wdata_ff[2:0] : 3'h0;

  // Hardware set wins over a software clear in the same cycle, so no
  // completion is ever lost; software sees the buffer empty and reloads it
  wire [2:0] clr_eff = clr_req & flags_ff & ~set_flag;
  wire [2:0] nxt_flags = init_active ? `CTF_FLAGS_RST : ((flags_ff & ~clr_eff) | set_flag);

  // The acknowledge lives until software hands the buffer over again
  wire [2:0] nxt_abort_ack = init_active ? 3'h0 : ((abort_ack_ff & ~clr_eff) | grant);

  // Requests only stick on scheduled buffers; a flag going empty drops them
  wire [2:0] abort_req_set = wr_abort_req ? (wdata_ff[2:0] & ~flags_ff) : 3'h0;
  wire [2:0] nxt_abort_req = init_active ? 3'h0 : ((abort_req_ff | abort_req_set) & ~set_flag);

  wire [2:0] nxt_txie = init_active ? `CTF_TXIE_RST : (wr_txie ? wdata_ff[2:0] : txie_ff);

  // Status records every empty event, enabled or not; a read clears, a new event wins
  wire [2:0] nxt_ist = (ist_ff & ~{3{rd_ist}}) | set_flag;

  // Receiver follows its engine, except on the bus-off to OK step of the transmitter
  wire tx_recover = bus_off_ff & ~core_in.tx_bus_off;
  wire ctf_rx_state_t nxt_rx_state = tx_recover ? CTF_RX_OK : core_in.rx_state;

  // ****************************************
  // Read mux
  // ****************************************
  // Init acknowledge is read-only; the write path ignores that bit
  wire [7:0] ctrl_rd = {3'h0, init_ak_ff, wake_irq_ff, wake_fn_ff, listen_ff, init_rq_ff};

  // Unmapped words read as zero, the response code tells them apart
  wire [7:0] rd_byte =
    hit(s_axi_araddr, `CTF_OFF_FLAGS) ? {5'h0, flags_ff} :
    hit(s_axi_araddr, `CTF_OFF_TXIE) ? {5'h0, txie_ff} :
    hit(s_axi_araddr, `CTF_OFF_CTRL) ? ctrl_rd :
    hit(s_axi_araddr, `CTF_OFF_ABORT_REQ) ? {5'h0, abort_req_ff} :
    hit(s_axi_araddr, `CTF_OFF_ABORT_ACK) ? {5'h0, abort_ack_ff} :
    hit(s_axi_araddr, `CTF_OFF_IST) ? {5'h0, ist_ff} :
    hit(s_axi_araddr, `CTF_OFF_IMSK) ? {5'h0, imsk_ff} : 8'h00;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  // Each channel is latched on its own handshake; the write is applied once
  // both halves are held, and neither is taken again until the response is gone
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_ok_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      w_ok_ff <= 1'b0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_ok_ff <= 1'b0;
      end
      if (w_hs) begin
        w_ok_ff <= 1'b1;
        wdata_ff <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_ok_ff <= 1'b0;
      end
    end
  end

  // Response stands until the master takes it
  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `CTF_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= mapped(awaddr_ff) ? `CTF_RESP_OKAY : `CTF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  // Read data is captured at the address handshake and held while rvalid stands,
  // so a late rready still sees the value of the request cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `CTF_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h0, rd_byte};
      rresp_ff <= mapped(s_axi_araddr) ? `CTF_RESP_OKAY : `CTF_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ****************************************
  // Flag, enable and abort state
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_ff <= `CTF_FLAGS_RST;
      txie_ff <= `CTF_TXIE_RST;
      abort_req_ff <= 3'h0;
      abort_ack_ff <= 3'h0;
      ist_ff <= 3'h0;
    end else begin
      // All next values are formed above; init mode is folded into all but nxt_ist
      flags_ff <= nxt_flags;
      txie_ff <= nxt_txie;
      abort_req_ff <= nxt_abort_req;
      abort_ack_ff <= nxt_abort_ack;
      ist_ff <= nxt_ist;
    end
  end

  // ****************************************
  // Control state
  // ****************************************
  // Acknowledge trails the request by one cycle, standing in for the engine's sync
  always_ff @(posedge clk) begin
    if (reset) begin
      init_rq_ff <= 1'b0;
      init_ak_ff <= 1'b0;
      listen_ff <= 1'b0;
      wake_fn_ff <= 1'b0;
      wake_irq_ff <= 1'b0;
      imsk_ff <= 3'h0;
    end else begin
      // Entry and exit both take a cycle, so registers stay protected in between
      init_ak_ff <= init_rq_ff;
      if (wr_ctrl) begin
        init_rq_ff <= wdata_ff[`CTF_CTRL_INIT_REQ_BIT];
        listen_ff <= wdata_ff[`CTF_CTRL_LISTEN_BIT];
        wake_fn_ff <= wdata_ff[`CTF_CTRL_WAKE_FN_BIT];
        wake_irq_ff <= wdata_ff[`CTF_CTRL_WAKE_IRQ_BIT];
      end
      // Mask stays writable in init mode so software can prepare it
      if (wr_imsk) begin
        imsk_ff <= wdata_ff[2:0];
      end
    end
  end

  // Previous bus-off level is kept to see the recovery step; the forced OK
  // lasts one cycle, after which the engine's own state is followed again
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_off_ff <= 1'b0;
      rx_state_ff <= CTF_RX_OK;
    end else begin
      bus_off_ff <= core_in.tx_bus_off;
      rx_state_ff <= nxt_rx_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = ~aw_ok_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_ok_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Ready is combinational from registers only, never from the valid inputs
  // Listen mode hides queued buffers from the engine but keeps them full
  assign core_out.tx_queued = ~flags_ff & {3{~listen_ff}};

  // Buffer RAM refuses access to any buffer that is handed over
  assign core_out.buf_blocked = ~flags_ff;
  assign core_out.listen_mode = listen_ff;

  // Software must set both for stop or wait recovery by bus activity
  assign core_out.wakeup_function_enable = wake_fn_ff;
  assign core_out.wakeup_irq_enable = wake_irq_ff;
  assign core_out.receiver_error_state = rx_state_ff;

  // tx_empty_irq drops as soon as its cause is gone; irq needs a status read or a mask clear
  assign tx_empty_irq = |(flags_ff & txie_ff);
  assign irq = |(ist_ff & imsk_ff);

endmodule

// ===== tb/ctf_engine_model.sv
// Purpose: Protocol engine stand-in that sends queued buffers
// Assumes: One frame at a time, lowest buffer first
// Notes: hold stalls the start, fail ends a frame without success
`timescale 1ns/100ps
module ctf_engine_model
  import ctf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] tx_queued,
  input wire logic hold,
  input wire logic fail,
  input wire logic bus_off,
  output ctf_core_in_t core_in
);
  logic [3:0] cnt_ff;
  logic [2:0] sel_ff;
  always_ff @(posedge clk) begin
    core_in.tx_done <= 3'h0;
    core_in.tx_failed <= 3'h0;
    core_in.tx_bus_off <= bus_off;
    core_in.rx_state <= bus_off ? CTF_RX_BUSOFF : CTF_RX_WARN;
    if (reset) begin
      sel_ff <= 3'h0;
      core_in.tx_active <= 3'h0;
    end else if (sel_ff == 3'h0) begin
      // Skip the cycle of a done pulse: the flag is not yet set and would restart the frame
      if (!hold && tx_queued != 3'h0 && core_in.tx_done == 3'h0) begin
        sel_ff <= tx_queued & (~tx_queued + 3'h1);
        cnt_ff <= 4'h9;
      end
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
      core_in.tx_active <= sel_ff;
    end else begin
      sel_ff <= 3'h0;
      core_in.tx_active <= 3'h0;
      if (fail) core_in.tx_failed <= sel_ff;
      else core_in.tx_done <= sel_ff;
    end
  end
endmodule

// ===== tb/ctf_testbench.sv
// Purpose: Self-checking bench of the transmit flag block
// Assumes: Engine model as far side, AXI4-Lite master tasks
// Notes: Tasks start one edge late so no handshake signal is driven twice at one edge
`timescale 1ns/100ps
module testbench
  import ctf_pkg::*;
;
`include "ctf_consts.svh"
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, v;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic hold = 1'b1, fail = 1'b0, bus_off = 1'b0;
  logic awr, wrd, bv, arr, rv, irq_tx, irq;
  logic [1:0] br, rr, r;
  ctf_core_in_t cin;
  ctf_core_out_t cout;
  int bad_count = 0, total_checks = 0;
  ctf_tx_flags uut (.clk(clk), .reset(reset), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .core_in(cin),
    .core_out(cout), .tx_empty_irq(irq_tx), .irq(irq));
  ctf_engine_model eng (.clk(clk), .reset(reset), .tx_queued(cout.tx_queued), .hold(hold), .fail(fail),
    .bus_off(bus_off), .core_in(cin));
  // ******
  // Bus and check tasks
  // ******
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    forever begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (bv && bre) begin
        r = br;
        bre <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    forever begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv && rre) begin
        v = rdat;
        r = rr;
        rre <= 1'b0;
        break;
      end
    end
    chk(n, v, e);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ******
  // Scenarios
  // ******
  task automatic t_send;
    rd("flags", `CTF_OFF_FLAGS, 32'h7);
    rd("enables", `CTF_OFF_TXIE, 32'h0);
    wr(`CTF_OFF_TXIE, 32'h1);
    wr(`CTF_OFF_IMSK, 32'h1);
    #1 chk("irq empty", irq_tx, 1);
    wr(`CTF_OFF_FLAGS, 32'h1); // Buffer 0 counts as loaded
    rd("clear", `CTF_OFF_FLAGS, 32'h6);
    #1 chk("irq per buffer", irq_tx, 0);
    chk("blocked", cout.buf_blocked, 3'h1);
    wr(`CTF_OFF_FLAGS, 32'h0);
    rd("zero ignored", `CTF_OFF_FLAGS, 32'h6);
    @(posedge clk);
    hold <= 1'b0;
    while (irq_tx !== 1'b1) @(posedge clk);
    rd("sent", `CTF_OFF_FLAGS, 32'h7);
    #1 chk("irq out", irq, 1);
    rd("status", `CTF_OFF_IST, 32'h1);
    #1 chk("irq cleared", irq, 0);
  endtask
  task automatic t_abort_listen;
    @(posedge clk);
    hold <= 1'b1;
    wr(`CTF_OFF_IMSK, 32'h0);
    wr(`CTF_OFF_FLAGS, 32'h2); // Buffer 1 counts as loaded
    wr(`CTF_OFF_ABORT_REQ, 32'h2);
    rd("aborted", `CTF_OFF_FLAGS, 32'h7);
    rd("ack", `CTF_OFF_ABORT_ACK, 32'h2);
    rd("req dropped", `CTF_OFF_ABORT_REQ, 32'h0);
    #1 chk("masked irq", irq, 0);
    rd("status", `CTF_OFF_IST, 32'h2);
    wr(`CTF_OFF_FLAGS, 32'h2);
    rd("ack cleared", `CTF_OFF_ABORT_ACK, 32'h0);
    wr(`CTF_OFF_CTRL, 32'h2);
    wr(`CTF_OFF_FLAGS, 32'h1);
    @(posedge clk);
    hold <= 1'b0;
    repeat (20) @(posedge clk);
    rd("listen", `CTF_OFF_FLAGS, 32'h5);
    wr(`CTF_OFF_CTRL, 32'h0);
    while (cout.buf_blocked !== 3'h0) @(posedge clk);
    rd("sent after", `CTF_OFF_FLAGS, 32'h7);
  endtask
  task automatic t_init_misc;
    wr(`CTF_OFF_CTRL, 32'h1);
    rd("init ack", `CTF_OFF_CTRL, 32'h11);
    rd("held", `CTF_OFF_TXIE, 32'h0);
    wr(`CTF_OFF_TXIE, 32'h7);
    rd("refused", `CTF_OFF_TXIE, 32'h0);
    wr(`CTF_OFF_CTRL, 32'h0);
    wr(`CTF_OFF_TXIE, 32'h7);
    rd("accepted", `CTF_OFF_TXIE, 32'h7);
    wr(`CTF_OFF_CTRL, 32'hc);
    rd("wake bits", `CTF_OFF_CTRL, 32'hc);
    chk("wake fn", cout.wakeup_function_enable, 1);
    chk("wake irq", cout.wakeup_irq_enable, 1);
    chk("listen pin", cout.listen_mode, 0);
    wr(`CTF_OFF_CTRL, 32'h0);
    @(posedge clk);
    bus_off <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("busoff", cout.receiver_error_state, CTF_RX_BUSOFF);
    @(posedge clk);
    bus_off <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("rx ok", cout.receiver_error_state, CTF_RX_OK);
    wr(8'h1c, 32'h1);
    chk("wr resp", r, `CTF_RESP_SLVERR);
    rd("unmapped", 8'h1c, 32'h0);
    chk("rd resp", r, `CTF_RESP_SLVERR);
  endtask
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_send;
    t_abort_listen;
    t_init_misc;
    complete_run;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    complete_run;
  end
endmodule

// ===== tb/ctf_tx_flags_assertions.sv
// Purpose: Port checker of the transmit flag block
// Assumes: One clock, synchronous active-high reset
// Notes: Empty flags are seen as the inverse of buf_blocked
`timescale 1ns/100ps
module ctf_tx_flags_checker
  import ctf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire ctf_core_in_t core_in,
  input wire ctf_core_out_t core_out,
  input wire logic tx_empty_irq
);
  // ******
  // Port relations
  // ******
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_reset_flags: assert property ($fell(reset) |-> core_out.buf_blocked == 3'h0)
    else $error("flags not empty after reset");
  a_done_sets: assert property (core_in.tx_done[0] && core_out.buf_blocked[0] |=> !core_out.buf_blocked[0])
    else $error("done left buffer full");
  a_busy_no_grant: assert property (core_in.tx_active[0] && !core_in.tx_failed[0] && !core_in.tx_done[0]
    && core_out.buf_blocked[0] |=> core_out.buf_blocked[0]) else $error("busy buffer released");
  a_irq_needs_flag: assert property (tx_empty_irq |-> core_out.buf_blocked != 3'h7)
    else $error("irq without empty flag");
  a_listen_idle: assert property (core_out.listen_mode |-> core_out.tx_queued == 3'h0)
    else $error("queued in listen mode");
  a_queue_blocked: assert property (
    core_out.tx_queued == (core_out.buf_blocked & {3{!core_out.listen_mode}})) else $error("queue mismatch");
  a_busoff_exit: assert property ($fell(core_in.tx_bus_off) |=> core_out.receiver_error_state == CTF_RX_OK)
    else $error("receiver not ok after bus-off");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
endmodule

bind ctf_tx_flags ctf_tx_flags_checker chk_i (.clk(clk), .reset(reset), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .core_in(core_in), .core_out(core_out),
  .tx_empty_irq(tx_empty_irq));
